// file: core/table_walk_index.sv
// Purpose: Translation table search with per-level index derivation
// Assumes: Physical memory answers one word per accepted fetch
// Notes: Contract
`timescale 1ns/10ps
`default_nettype none
module table_walk_index
    import walk_pkg::*;
#(
    parameter int NUM_LEVELS = 5
) (
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire walk_pkg::walk_req_type i_miss,
    output logic o_miss_ready,
    input wire walk_pkg::walk_req_type i_module_call,
    output logic o_module_ready,
    output walk_pkg::walk_res_type o_result,
    output walk_pkg::mem_req_type o_mem,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_irq
);
    import walk_pkg::*;

    if (NUM_LEVELS != 5) begin : g_level_check
        $error("table_walk_index serves exactly five levels");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    // Field of width w whose top bit lies pos bits below bit 31
    function automatic logic [14:0] index_field(input logic [31:0] a,
                                               input logic [5:0] pos,
                                               input logic [3:0] w);
        logic [31:0] s;
        logic [14:0] t;
        s = a << pos;
        t = s[31:17];
        return t >> (4'hf - w);
    endfunction : index_field

    function automatic logic [3:0] tc_field(input logic [31:0] tc,
                                            input int lsb);
        return tc[lsb +: 4];
    endfunction : tc_field

    ////////////////////////////////////////////////////////////////////////
    // Registers and state
    typedef enum logic [1:0] {
        st_idle,
        st_index,
        st_fetch,
        st_finish
    } walk_state_type;

    walk_state_type state_r, state_nxt;
    logic [31:0] ctrl_r, sup_root_r, user_root_r, dma_root_r;
    logic [31:0] test_addr_r;
    logic [7:0] test_cmd_r;
    logic test_pend_r;
    logic [irq_bits-1:0] irq_sts_r, irq_en_r, irq_set;
    logic [31:0] hrdata_r;
    logic dp_write_r;
    logic [7:0] dp_addr_r;
    walk_res_type res_r, res_nxt;
    walk_req_type req_r, req_nxt;
    source_type src_r, src_nxt;
    logic [2:0] lvl_r, lvl_nxt;
    logic [5:0] pos_r, pos_nxt;
    logic [31:0] base_r, base_nxt;
    logic [5:0] scale_r, scale_nxt;
    logic [31:0] mem_addr_r, mem_addr_nxt;

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY
    wire addr_phase = i_hsel && i_htrans[1] && i_hready;
    wire wr_en = dp_write_r;
    wire wr_ctrl = wr_en && dp_addr_r == ctrl_off;
    wire wr_sup = wr_en && dp_addr_r == sup_root_off;
    wire wr_user = wr_en && dp_addr_r == user_root_off;
    wire wr_dma = wr_en && dp_addr_r == dma_root_off;
    wire wr_cmd = wr_en && dp_addr_r == test_cmd_off;
    wire wr_taddr = wr_en && dp_addr_r == test_addr_off;
    wire wr_clr = wr_en && dp_addr_r == irq_clear_off;
    wire wr_ien = wr_en && dp_addr_r == irq_enable_off;

    // Status word: busy, pending test, error code, level the walk ended at
    wire busy = state_r != st_idle;
    wire [31:0] status_word = {23'h0, res_r.level, res_r.error, 1'b0,
                               res_r.valid, test_pend_r, busy};
    logic [31:0] rd_mux;
    always_comb begin
        case (i_haddr[7:0])
            ctrl_off: rd_mux = ctrl_r;
            sup_root_off: rd_mux = sup_root_r;
            user_root_off: rd_mux = user_root_r;
            dma_root_off: rd_mux = dma_root_r;
            test_cmd_off: rd_mux = {24'h0, test_cmd_r};
            test_addr_off: rd_mux = test_addr_r;
            walk_status_off: rd_mux = status_word;
            walk_frame_off: rd_mux = res_r.frame;
            irq_status_off: rd_mux = {30'h0, irq_sts_r};
            irq_enable_off: rd_mux = {30'h0, irq_en_r};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            dp_write_r <= 1'b0;
            dp_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end else if (i_hready) begin
            dp_write_r <= addr_phase && i_hwrite;
            dp_addr_r <= i_haddr[7:0];
            hrdata_r <= (addr_phase && !i_hwrite && i_haddr[31:8] == 24'h0)
                        ? rd_mux : 32'h0000_0000;
        end
    end

    assign o_hrdata = hrdata_r;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ctrl_r <= tc_reset;
            sup_root_r <= root_reset;
            user_root_r <= root_reset;
            dma_root_r <= root_reset;
            test_addr_r <= 32'h0000_0000;
            test_cmd_r <= 8'h00;
            irq_en_r <= '0;
        end else begin
            if (wr_ctrl) ctrl_r <= i_hwdata;
            if (wr_sup) sup_root_r <= i_hwdata;
            if (wr_user) user_root_r <= i_hwdata;
            if (wr_dma) dma_root_r <= i_hwdata;
            if (wr_taddr) test_addr_r <= i_hwdata;
            if (wr_cmd) test_cmd_r <= i_hwdata[7:0];
            if (wr_ien) irq_en_r <= i_hwdata[irq_bits-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Request selection
    // A go written while busy waits as pending and starts when idle
    wire take_test = test_pend_r && !busy;
    wire tc_on = ctrl_r[tc_enable_pos];
    wire take_miss = !busy && !test_pend_r && i_miss.valid && tc_on;
    wire take_mod = !busy && !test_pend_r && !i_miss.valid
                    && i_module_call.valid;
    assign o_miss_ready = !busy && !test_pend_r && tc_on;
    assign o_module_ready = !busy && !test_pend_r && !i_miss.valid;

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            test_pend_r <= 1'b0;
        end else if (wr_cmd && i_hwdata[cmd_go_pos]) begin
            test_pend_r <= 1'b1;
        end else if (take_test) begin
            test_pend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Index derivation
    wire [3:0] tc_is = tc_field(ctrl_r, tc_is_pos);
    wire [3:0] level_a_index_width = tc_field(ctrl_r, tc_tia_pos);
    wire [3:0] level_b_index_width = tc_field(ctrl_r, tc_tib_pos);
    wire [3:0] level_c_index_width = tc_field(ctrl_r, tc_tic_pos);
    wire [3:0] level_d_index_width = tc_field(ctrl_r, tc_tid_pos);
    // DMA tree always takes the code level; others only under lookup
    wire use_fc = req_r.fc[3] || ctrl_r[tc_fcl_pos];
    // Tree ends at the last level with a non-zero width
    wire [2:0] last_lvl = (level_d_index_width != 4'h0) ? 3'd4 : (level_c_index_width != 4'h0) ? 3'd3 :
                          (level_b_index_width != 4'h0) ? 3'd2 : 3'd1;
    logic [3:0] cur_w;
    always_comb begin
        case (lvl_r)
            3'd0: cur_w = use_fc ? fc_index_width : 4'h0;
            3'd1: cur_w = level_a_index_width;
            3'd2: cur_w = level_b_index_width;
            3'd3: cur_w = level_c_index_width;
            3'd4: cur_w = level_d_index_width;
            default: cur_w = 4'h0;
        endcase
    end
    // Code level indexes by the three low code bits, eight entries
    wire [14:0] cur_idx = (lvl_r == 3'd0) ? {12'h0, req_r.fc[2:0]}
                          : index_field(req_r.addr, pos_r, cur_w);
    wire [31:0] entry_addr = base_r + ({17'h0, cur_idx} << scale_r);

    // Root pick: code bit three selects DMA, bit two supervisor
    wire [3:0] new_fc = take_test ? test_cmd_r[cmd_fc_pos +: 4]
                        : take_miss ? i_miss.fc : i_module_call.fc;
    wire [31:0] root_sel = new_fc[3] ? dma_root_r
                           : new_fc[2] ? sup_root_r : user_root_r;
    wire [1:0] mem_dt = i_mem_rdata[1:0];

    ////////////////////////////////////////////////////////////////////////
    // Walk sequencer
    always_comb begin
        state_nxt = state_r;
        req_nxt = req_r;
        src_nxt = src_r;
        lvl_nxt = lvl_r;
        pos_nxt = pos_r;
        base_nxt = base_r;
        scale_nxt = scale_r;
        mem_addr_nxt = mem_addr_r;
        res_nxt = res_r;
        irq_set = '0;
        case (state_r)
            st_idle: begin
                if (take_test || take_miss || take_mod) begin
                    if (take_test) begin
                        req_nxt.addr = test_addr_r;
                        req_nxt.write = test_cmd_r[cmd_write_pos];
                        src_nxt = test_cmd_r[cmd_preload_pos]
                                  ? src_preload : src_test;
                    end else if (take_miss) begin
                        req_nxt.addr = i_miss.addr;
                        req_nxt.write = i_miss.write;
                        src_nxt = src_miss;
                    end else begin
                        req_nxt.addr = i_module_call.addr;
                        req_nxt.write = i_module_call.write;
                        src_nxt = src_module;
                    end
                    req_nxt.fc = new_fc;
                    req_nxt.valid = 1'b1;
                    // Top initial-shift bits never enter an index
                    pos_nxt = {2'b00, tc_is};
                    lvl_nxt = 3'd0;
                    base_nxt = {root_sel[31:desc_base_lsb],
                                {desc_base_lsb{1'b0}}};
                    scale_nxt = (root_sel[1:0] == dt_long)
                                ? long_scale : short_scale;
                    res_nxt.valid = 1'b0;
                    state_nxt = st_index;
                end
            end
            st_index: begin
                if (cur_w == 4'h0) begin
                    // Without lookup the root addresses level A directly
                    lvl_nxt = lvl_r + 3'd1;
                end else begin
                    mem_addr_nxt = entry_addr;
                    state_nxt = st_fetch;
                end
            end
            st_fetch: begin
                if (i_mem_ack) begin
                    res_nxt.level = lvl_r;
                    res_nxt.frame = 32'h0000_0000;
                    state_nxt = st_finish;
                    if (mem_dt == dt_invalid) begin
                        res_nxt.error = err_invalid;
                    end else if (req_r.write && i_mem_rdata[desc_wp_pos]) begin
                        res_nxt.error = err_protect;
                    end else if (mem_dt == dt_page) begin
                        res_nxt.error = err_none;
                        res_nxt.frame = {i_mem_rdata[31:desc_base_lsb],
                                         {desc_base_lsb{1'b0}}};
                    end else if (lvl_r >= last_lvl) begin
                        res_nxt.error = err_depth;
                    end else begin
                        base_nxt = {i_mem_rdata[31:desc_base_lsb],
                                    {desc_base_lsb{1'b0}}};
                        scale_nxt = (mem_dt == dt_long)
                                    ? long_scale : short_scale;
                        if (lvl_r != 3'd0) begin
                            pos_nxt = pos_r + {2'b00, cur_w};
                        end
                        lvl_nxt = lvl_r + 3'd1;
                        state_nxt = st_index;
                    end
                end
            end
            st_finish: begin
                res_nxt.valid = 1'b1;
                irq_set[irq_done_pos] = 1'b1;
                irq_set[irq_error_pos] = res_r.error != err_none;
                state_nxt = st_idle;
            end
            default: state_nxt = st_idle;
        endcase
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            state_r <= st_idle;
            req_r <= '0;
            src_r <= src_miss;
            lvl_r <= 3'd0;
            pos_r <= 6'h00;
            base_r <= 32'h0000_0000;
            scale_r <= short_scale;
            mem_addr_r <= 32'h0000_0000;
            res_r <= '0;
        end else begin
            state_r <= state_nxt;
            req_r <= req_nxt;
            src_r <= src_nxt;
            lvl_r <= lvl_nxt;
            pos_r <= pos_nxt;
            base_r <= base_nxt;
            scale_r <= scale_nxt;
            mem_addr_r <= mem_addr_nxt;
            res_r <= res_nxt;
        end
    end

    // Result pulses for one cycle after the walk ends
    logic done_pulse_r;
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            done_pulse_r <= 1'b0;
        end else begin
            done_pulse_r <= state_r == st_finish;
        end
    end
    assign o_result = '{valid: done_pulse_r, error: res_r.error,
                        level: res_r.level, frame: res_r.frame};
    assign o_mem = '{valid: state_r == st_fetch, addr: mem_addr_r};

    ////////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over a clear in the same cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            irq_sts_r <= '0;
        end else begin
            irq_sts_r <= (irq_sts_r & ~(wr_clr ? i_hwdata[irq_bits-1:0]
                                         : {irq_bits{1'b0}})) | irq_set;
        end
    end
    assign o_irq = |(irq_sts_r & irq_en_r);
endmodule : table_walk_index
`default_nettype wire

// file: core/walk_pkg.sv
// Purpose: Shared constants and carriers for the table walk index block
// Assumes: 32-bit logical and physical addresses, AHB-Lite register access
// Notes: Register offsets are byte addresses of aligned words
package walk_pkg;
    // Register map
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] sup_root_off = 8'h04;
    localparam logic [7:0] user_root_off = 8'h08;
    localparam logic [7:0] dma_root_off = 8'h0c;
    localparam logic [7:0] test_cmd_off = 8'h10;
    localparam logic [7:0] test_addr_off = 8'h14;
    localparam logic [7:0] walk_status_off = 8'h18;
    localparam logic [7:0] walk_frame_off = 8'h1c;
    localparam logic [7:0] irq_status_off = 8'h20;
    localparam logic [7:0] irq_clear_off = 8'h24;
    localparam logic [7:0] irq_enable_off = 8'h28;
    // translation_control fields
    localparam int tc_enable_pos = 31;
    localparam int tc_fcl_pos = 24;
    localparam int tc_ps_pos = 20;
    localparam int tc_is_pos = 16;
    localparam int tc_tia_pos = 12;
    localparam int tc_tib_pos = 8;
    localparam int tc_tic_pos = 4;
    localparam int tc_tid_pos = 0;
    localparam logic [31:0] tc_reset = 32'h0000_0000;
    localparam logic [31:0] root_reset = 32'h0000_0000;
    // Test command fields
    localparam int cmd_go_pos = 0;
    localparam int cmd_preload_pos = 1;
    localparam int cmd_write_pos = 2;
    localparam int cmd_fc_pos = 4;
    // Descriptor and pointer layout
    localparam logic [1:0] dt_invalid = 2'h0;
    localparam logic [1:0] dt_page = 2'h1;
    localparam logic [1:0] dt_short = 2'h2;
    localparam logic [1:0] dt_long = 2'h3;
    localparam int desc_wp_pos = 2;
    localparam int desc_base_lsb = 4;
    localparam logic [5:0] short_scale = 6'h02;
    localparam logic [5:0] long_scale = 6'h03;
    localparam logic [3:0] fc_index_width = 4'h3;
    localparam logic [5:0] addr_bits = 6'h20;
    // Result codes
    localparam logic [1:0] err_none = 2'h0;
    localparam logic [1:0] err_invalid = 2'h1;
    localparam logic [1:0] err_protect = 2'h2;
    localparam logic [1:0] err_depth = 2'h3;
    // Interrupt events
    localparam int irq_done_pos = 0;
    localparam int irq_error_pos = 1;
    localparam int irq_bits = 2;

    typedef enum logic [1:0] {
        src_miss,
        src_module,
        src_test,
        src_preload
    } source_type;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [3:0] fc;
        logic write;
    } walk_req_type;

    typedef struct packed {
        logic valid;
        logic [1:0] error;
        logic [2:0] level;
        logic [31:0] frame;
    } walk_res_type;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } mem_req_type;
endpackage : walk_pkg

// file: tb/tb.sv
// Purpose: Self-checking bench for the table walk index block
// Assumes: Memory model answers each fetch after wait_cyc cycles
// Notes: Tables sit at fixed small physical addresses
`timescale 1ns/10ps
`default_nettype none
module tb;
    import walk_pkg::*;
    logic i_sys_clk, i_reset, i_hsel, i_hwrite, o_hreadyout, o_hresp;
    logic o_miss_ready, o_module_ready, i_mem_ack, o_irq;
    logic [1:0] i_htrans;
    logic [31:0] i_haddr, i_hwdata, o_hrdata, i_mem_rdata, q;
    logic [3:0] wait_cyc;
    wire logic i_hready = o_hreadyout;
    wire logic [2:0] i_hsize = 3'h2;
    walk_req_type i_miss, i_module_call;
    walk_res_type o_result, res;
    mem_req_type o_mem;
    logic [31:0] fa [$];
    int n_fail, total_checks, n;
    // Physical address in the upper word, descriptor in the lower
    logic [63:0] tab [9] = '{64'h1028_0000_2002, 64'h2018_0005_4001,
        64'h201c_0000_2002, 64'h1030_0009_9005, 64'h3028_0000_4002,
        64'h4014_0000_5003, 64'h5558_0007_7001, 64'h6008_0000_7002,
        64'h7028_0008_8001};
    table_walk_index dut (
        .i_sys_clk, .i_reset, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
        .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
        .i_miss, .o_miss_ready, .i_module_call, .o_module_ready, .o_result,
        .o_mem, .i_mem_ack, .i_mem_rdata, .o_irq
    );
    walk_mem_model u_mem (.i_sys_clk, .i_reset, .i_req(o_mem),
        .i_wait(wait_cyc), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
    ////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic note(input string s);
        $display("test %s done", s);
    endtask : note
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        i_hsel <= 1'b1;
        i_htrans <= 2'h2;
        i_haddr <= {24'h0, a};
        i_hwrite <= w;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        do @(posedge i_sys_clk); while (i_hready !== 1'b1);
        q = o_hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    task automatic walk(input logic m, input logic [31:0] a,
                        input logic [3:0] fc, input logic w);
        fa.delete();
        if (m) i_module_call <= '{1'b1, a, fc, w};
        else i_miss <= '{1'b1, a, fc, w};
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while ((m ? o_module_ready : o_miss_ready) !== 1'b1 && n < 99);
        i_miss.valid <= 1'b0;
        i_module_call.valid <= 1'b0;
        n = 0;
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_result.valid !== 1'b1 && n < 200);
        chk({31'h0, o_result.valid}, 32'h1);
        res = o_result;
    endtask : walk
    task automatic echk(input logic [1:0] e);
        chk({30'h0, res.error}, {30'h0, e});
    endtask : echk
    always @(posedge i_sys_clk) begin
        if (o_mem.valid && i_mem_ack) fa.push_back(o_mem.addr);
    end
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // The whole run takes well under a thousand cycles
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_fail++;
        end_sim();
    end
    ////////////////////////////////////////
    initial begin
        i_reset = 1'b1;
        i_hsel = 1'b0;
        i_htrans = 2'h0;
        i_haddr = 32'h0;
        i_hwrite = 1'b0;
        i_hwdata = 32'h0;
        i_miss = '0;
        i_module_call = '0;
        wait_cyc = 4'h0;
        foreach (tab[i]) u_mem.put(tab[i][63:32], tab[i][31:0]);
        repeat (16) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        @(posedge i_sys_clk);
        rd(ctrl_off, tc_reset);
        rd(user_root_off, root_reset);
        rd(irq_status_off, 32'h0);
        chk({31'h0, o_miss_ready}, 32'h0);
        bus(1'b1, 8'h2c, 32'hffff_ffff);
        rd(8'h2c, 32'h0);
        note("reset");
        bus(1'b1, ctrl_off, 32'h80a0_ca00);
        bus(1'b1, user_root_off, 32'h0000_1002);
        bus(1'b1, dma_root_off, 32'h0000_6002);
        bus(1'b1, sup_root_off, 32'h0000_3003);
        walk(1'b0, 32'h00a0_1a00, 4'h1, 1'b0);
        chk(res.frame, 32'h0005_4000);
        chk(fa[0], 32'h0000_1028);
        chk(fa[1], 32'h0000_2018);
        chk({29'h0, res.level}, 32'h2);
        walk(1'b0, 32'h00a0_1c00, 4'h1, 1'b0);
        echk(err_depth);
        walk(1'b0, 32'h00c0_0000, 4'h1, 1'b1);
        echk(err_protect);
        walk(1'b0, 32'h00c0_0000, 4'h1, 1'b0);
        chk(res.frame, 32'h0009_9000);
        chk({31'h0, o_irq}, 32'h0);
        note("user tree");
        bus(1'b1, irq_clear_off, 32'h3);
        bus(1'b1, irq_enable_off, 32'h3);
        rd(irq_status_off, 32'h0);
        walk(1'b0, 32'h00b0_0000, 4'h1, 1'b0);
        echk(err_invalid);
        chk({31'h0, o_irq}, 32'h1);
        bus(1'b0, irq_status_off, 32'h0);
        chk(q & 32'h2, 32'h2);
        bus(1'b1, irq_clear_off, 32'h3);
        rd(irq_status_off, 32'h0);
        chk({31'h0, o_irq}, 32'h0);
        note("interrupt");
        bus(1'b1, test_addr_off, 32'h00a0_1a00);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, test_cmd_off, (i == 1) ? 32'h13 : 32'h11);
            n = 0;
            do begin
                bus(1'b0, walk_status_off, 32'h0);
                n++;
            end while (q[1:0] !== 2'h0 && n < 50);
            chk(q & 32'h37, 32'h4);
            rd(walk_frame_off, 32'h0005_4000);
        end
        note("test command");
        wait_cyc <= 4'h3;
        walk(1'b0, 32'h00a0_1a00, 4'ha, 1'b0);
        chk(fa[0], 32'h0000_6008);
        chk(res.frame, 32'h0008_8000);
        bus(1'b1, ctrl_off, 32'h81c8_4800);
        walk(1'b1, 32'hff5a_b123, 4'h5, 1'b0);
        chk(fa[0], 32'h0000_3028);
        chk(fa[1], 32'h0000_4014);
        chk(fa[2], 32'h0000_5558);
        chk(res.frame, 32'h0007_7000);
        note("code level");
        end_sim();
    end
endmodule : tb
bind table_walk_index walk_asserts u_chk (.i_sys_clk, .i_reset, .i_hsel,
    .i_haddr, .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout,
    .o_hresp, .i_miss, .o_miss_ready, .i_module_call, .o_module_ready,
    .o_result, .o_mem, .i_mem_ack, .o_irq);
`default_nettype wire

// file: tb/walk_asserts.sv
// Purpose: Port-level checks of the table walk index block
// Assumes: Single clock, synchronous active-high reset
// Notes: Control and roots are shadowed from observed bus writes
`timescale 1ns/10ps
`default_nettype none
module walk_asserts
    import walk_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    input wire walk_req_type i_miss,
    input wire logic o_miss_ready,
    input wire walk_req_type i_module_call,
    input wire logic o_module_ready,
    input wire walk_res_type o_result,
    input wire mem_req_type o_mem,
    input wire logic i_mem_ack,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    logic wr_r, first_r;
    logic [3:0] wa_r, fc_r;
    logic [31:0] addr_r;
    logic [31:0] sh_r [16];
    wire logic take_m = i_miss.valid & o_miss_ready;
    wire logic take_c = i_module_call.valid & o_module_ready;
    wire walk_req_type req = take_m ? i_miss : i_module_call;
    wire logic [31:0] ctrl = sh_r[0];
    wire logic [31:0] root = fc_r[3] ? sh_r[3] : (fc_r[2] ? sh_r[1] : sh_r[2]);
    wire logic use_fc = fc_r[3] | ctrl[tc_fcl_pos];
    wire logic [31:0] ia = (addr_r << ctrl[19:16])
        >> (6'd32 - {2'h0, ctrl[15:12]});
    wire logic [31:0] idx = use_fc ? {29'h0, fc_r[2:0]} : ia;
    wire logic [5:0] sc = (root[1:0] == dt_long) ? long_scale : short_scale;
    wire logic [31:0] exp_a = {root[31:4], 4'h0} + (idx << sc);
    ////////////////////////////////////////
    // A write lands at the end of its data phase, as in the block
    always_ff @(posedge i_sys_clk) begin
        wr_r <= ~i_reset & i_hsel & i_htrans[1] & i_hready & i_hwrite
            & (i_haddr[31:6] == 26'h0);
        wa_r <= i_haddr[5:2];
        if (take_m | take_c) begin
            addr_r <= req.addr;
            fc_r <= req.fc;
        end
        first_r <= ~i_reset & (take_m | take_c | (first_r & ~o_mem.valid));
        if (i_reset) begin
            for (int k = 0; k < 16; k++) begin
                sh_r[k] <= 32'h0;
            end
        end else if (wr_r) begin
            sh_r[wa_r] <= i_hwdata;
        end
    end
    sequence s_take;
        (take_m | take_c);
    endsequence
    sequence s_done;
        ##[2:80] o_result.valid;
    endsequence
    ////////////////////////////////////////
    a_walk_bounded:
        assert property (s_take |-> s_done)
        else $error("walk did not finish in time");
    a_one_walk:
        assert property (s_take |=> (!o_miss_ready && !o_module_ready) [*2])
        else $error("second walk taken while busy");
    a_fetch_holds:
        assert property (o_mem.valid && !i_mem_ack
            |=> o_mem.valid && $stable(o_mem.addr))
        else $error("fetch dropped before ack");
    a_result_pulse:
        assert property (o_result.valid |=> !o_result.valid)
        else $error("result valid longer than one cycle");
    a_code_first:
        assert property (first_r && o_mem.valid && use_fc
            |-> o_mem.addr == exp_a)
        else $error("first fetch not the code table entry");
    a_level_a_first:
        assert property (first_r && o_mem.valid && !use_fc
            |-> o_mem.addr == exp_a)
        else $error("first fetch not the level A entry");
    a_miss_gated:
        assert property (!ctrl[tc_enable_pos] |-> !o_miss_ready)
        else $error("miss accepted while translation off");
    a_irq_follows:
        assert property (o_result.valid && sh_r[10][irq_done_pos]
            |-> ##[0:1] o_irq)
        else $error("enabled completion raised no interrupt");
    a_bus_okay:
        assert property (o_hreadyout && !o_hresp)
        else $error("bus slave stalled or answered error");
endmodule : walk_asserts
`default_nettype wire

// file: tb/walk_mem_model.sv
// Purpose: Physical memory holding translation tables
// Assumes: One word per fetch, answered after i_wait cycles
// Notes: Unwritten words read as zero, the invalid descriptor
`timescale 1ns/10ps
`default_nettype none
module walk_mem_model
    import walk_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_reset,
    input wire mem_req_type i_req,
    input wire logic [3:0] i_wait,
    output logic o_ack,
    output logic [31:0] o_rdata
);
    logic [31:0] mem [bit [31:0]];
    logic [3:0] cnt_r;
    task automatic put(input logic [31:0] a, input logic [31:0] d);
        mem[a] = d;
    endtask : put
    function automatic logic [31:0] peek(input logic [31:0] a);
        return mem.exists(a) ? mem[a] : 32'h0;
    endfunction : peek
    ////////////////////////////////////////
    initial begin
        o_ack = 1'b0;
        o_rdata = 32'h0;
        cnt_r = 4'h0;
    end
    // Data toggles outside the ack cycle so a stale word never passes
    always @(posedge i_sys_clk) begin
        if (i_reset | o_ack | !i_req.valid) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            cnt_r <= 4'h0;
        end else if (cnt_r == i_wait) begin
            o_ack <= 1'b1;
            o_rdata <= peek(i_req.addr);
        end else begin
            cnt_r <= cnt_r + 4'h1;
            o_rdata <= ~o_rdata;
        end
    end
endmodule : walk_mem_model
`default_nettype wire
